/* rtl/tcc_pkg.sv */
// Purpose: shared constants for the timer capture/compare unit
// Assumes: 8-bit register port with byte addresses
// Notes: each 16-bit value occupies a byte pair, high byte first
package tcc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [4:0] ADDR_EDGE_SEL = 5'h00;
  // Value pair k: high byte at base + 2k, low byte one above
  localparam logic [4:0] ADDR_VALUE_BASE = 5'h02;
  localparam logic [4:0] ADDR_FORCE = 5'h12;
  localparam logic [4:0] ADDR_PIN_MASK = 5'h13;
  localparam logic [4:0] ADDR_PIN_DATA = 5'h14;
  localparam logic [4:0] ADDR_ACTION = 5'h15;
  localparam logic [4:0] ADDR_FLAG = 5'h16;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h17;
  localparam logic [4:0] ADDR_FUNC_SEL = 5'h18;

  // ************************************************************
  // Layout
  // ************************************************************
  localparam int NUM_VALUES = 8;
  localparam int NUM_CAPTURE = 4;
  localparam int NUM_COMPARE = 5;
  localparam int SHARED_INDEX = 3;
  localparam int COMPARE_ONE_INDEX = 4;
  localparam int FUNC_SEL_BIT = 0;
  localparam int EDGE_RISE_BIT = 0;
  localparam int EDGE_FALL_BIT = 1;
  localparam int PIN_LOW = 3;
  localparam int PIN_HIGH = 7;
  // Bits 2:0 of force, mask and data are unimplemented
  localparam logic [7:0] PIN_FIELD_MASK = 8'hf8;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [15:0] COMPARE_RESET = 16'hffff;
  localparam logic [7:0] CONTROL_RESET = 8'h00;

  // Pin action on a compare event
  typedef enum logic [1:0] {
    ACT_OFF = 2'b00,
    ACT_TOGGLE = 2'b01,
    ACT_SET = 2'b11,
    ACT_CLEAR = 2'b10
  } pin_action_e;

endpackage

/* rtl/timer_capture_compare_unit.sv */
// Purpose: capture/compare logic around a free-running 16-bit count
// Assumes: count and pins are synchronous to i_mclk
// Notes: the three dedicated capture registers hold their value through reset; the shared pair resets
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ps
module timer_capture_compare_unit #(
  parameter int COUNT_W = 16
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic [4:0] i_addr,
  input wire logic [7:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rd_data,
  input wire logic [COUNT_W-1:0] i_free_running_count,
  input wire logic i_count_tick,
  input wire logic [3:0] i_port_a,
  output logic [7:3] o_port_a_out,
  output logic [7:3] o_port_a_oe,
  output logic o_irq
);

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [7:0] edge_sel_reg;
  logic [7:0] action_reg;
  logic [7:0] mask_reg;
  logic [7:0] data_reg;
  logic [7:0] flag_reg;
  logic [7:0] flag_next;
  logic [7:0] irq_mask_reg;
  logic func_sel_reg;
  logic [COUNT_W-1:0] val [tcc_pkg::NUM_VALUES];
  logic [COUNT_W-1:0] cap_val [tcc_pkg::NUM_CAPTURE];
  logic [tcc_pkg::NUM_VALUES-1:0] hi_wr;
  logic [tcc_pkg::NUM_VALUES-1:0] lo_wr;
  logic [tcc_pkg::NUM_VALUES-1:0] hi_rd;
  logic [tcc_pkg::NUM_VALUES-1:0] load_v;
  logic [tcc_pkg::NUM_CAPTURE-1:0] cap_evt;
  logic [tcc_pkg::NUM_CAPTURE-1:0] cap_load;
  logic [tcc_pkg::NUM_COMPARE-1:0] match;
  logic [tcc_pkg::NUM_COMPARE-1:0] force_go;
  logic [tcc_pkg::NUM_COMPARE-1:0] cmp_evt;
  logic [7:0] flag_set;
  logic [3:0] cap_set;
  logic [7:3] cmp_set;
  logic [7:0] flag_clr;
  logic [7:3] pin_next;
  logic [7:3] oe_next;
  logic [7:0] rd_mux;
  logic force_wr;

  // ************************************************************
  // Control register decode
  // ************************************************************
  // Write strobes for the force and flag registers
  assign force_wr = i_wr && (i_addr == tcc_pkg::ADDR_FORCE);
  assign flag_clr = (i_wr && (i_addr == tcc_pkg::ADDR_FLAG)) ? i_wr_data : 8'h00;
  // Bit 3 is shared; only one of capture four and compare five is enabled
  assign flag_set = {cmp_set[7:4], cmp_set[3] | cap_set[3], cap_set[2:0]};
  // Set wins over a clear in the same cycle
  assign flag_next = (flag_reg & ~flag_clr) | flag_set;
  assign load_v = {4'h0, cap_load};

  // Control registers; edge select starts out disabled
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      edge_sel_reg <= tcc_pkg::CONTROL_RESET;
      action_reg <= tcc_pkg::CONTROL_RESET;
      mask_reg <= tcc_pkg::CONTROL_RESET;
      data_reg <= tcc_pkg::CONTROL_RESET;
      irq_mask_reg <= tcc_pkg::CONTROL_RESET;
      flag_reg <= tcc_pkg::CONTROL_RESET;
      func_sel_reg <= 1'b0;
    end else begin
      flag_reg <= flag_next;
      if (i_wr && (i_addr == tcc_pkg::ADDR_EDGE_SEL)) begin
        edge_sel_reg <= i_wr_data;
      end
      if (i_wr && (i_addr == tcc_pkg::ADDR_ACTION)) begin
        action_reg <= i_wr_data;
      end
      if (i_wr && (i_addr == tcc_pkg::ADDR_PIN_MASK)) begin
        mask_reg <= i_wr_data & tcc_pkg::PIN_FIELD_MASK;
      end
      if (i_wr && (i_addr == tcc_pkg::ADDR_PIN_DATA)) begin
        data_reg <= i_wr_data & tcc_pkg::PIN_FIELD_MASK;
      end
      if (i_wr && (i_addr == tcc_pkg::ADDR_IRQ_MASK)) begin
        irq_mask_reg <= i_wr_data;
      end
      if (i_wr && (i_addr == tcc_pkg::ADDR_FUNC_SEL)) begin
        func_sel_reg <= i_wr_data[tcc_pkg::FUNC_SEL_BIT];
      end
    end
  end

  // ************************************************************
  // Value register pairs
  // ************************************************************
  for (genvar k = 0; k < tcc_pkg::NUM_VALUES; k++) begin : g_val
    localparam logic [4:0] HI_ADDR = tcc_pkg::ADDR_VALUE_BASE + 5'(2 * k);
    localparam logic [4:0] LO_ADDR = HI_ADDR + 5'h01;
    logic [COUNT_W-1:0] v_reg;
    logic sw_ok;
    // Byte strobes; the shared pair ignores writes in capture mode
    assign hi_wr[k] = i_wr && (i_addr == HI_ADDR);
    assign lo_wr[k] = i_wr && (i_addr == LO_ADDR);
    assign hi_rd[k] = i_rd && (i_addr == HI_ADDR);
    assign sw_ok = (k > tcc_pkg::SHARED_INDEX) ||
                   ((k == tcc_pkg::SHARED_INDEX) && !func_sel_reg);
    assign val[k] = v_reg;
    if (k < tcc_pkg::SHARED_INDEX) begin : g_cap_only
      // No reset term: captured times survive a reset
      always_ff @(posedge i_mclk) begin
        if (load_v[k]) begin
          v_reg <= cap_val[k];
        end
      end
    end else begin : g_cmp
      // Compare storage, all ones out of reset
      always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
          v_reg <= tcc_pkg::COMPARE_RESET;
        end else if (load_v[k]) begin
          v_reg <= cap_val[tcc_pkg::SHARED_INDEX];
        end else begin
          if (sw_ok && hi_wr[k]) begin
            v_reg[15:8] <= i_wr_data;
          end
          if (sw_ok && lo_wr[k]) begin
            v_reg[7:0] <= i_wr_data;
          end
        end
      end
    end
  end

  // ************************************************************
  // Input capture channels
  // ************************************************************
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  for (genvar n = 0; n < tcc_pkg::NUM_CAPTURE; n++) begin : g_cap
    localparam int P = (n == 3) ? 3 : 2 - n;
    localparam int E = (n == 3) ? 6 : 4 - 2 * n;
    logic prev_reg;
    logic blk;
    logic hold_reg;
    logic [COUNT_W-1:0] hold_val_reg;
    logic rise;
    logic fall;
    logic en;
    // Edge detect against last sample; each channel stands alone
    assign rise = i_port_a[P] && !prev_reg;
    assign fall = !i_port_a[P] && prev_reg;
    assign en = (n != 3) || func_sel_reg;
    assign cap_evt[n] = en && ((edge_sel_reg[E + tcc_pkg::EDGE_RISE_BIT] && rise) ||
                               (edge_sel_reg[E + tcc_pkg::EDGE_FALL_BIT] && fall));
    // A load in the high byte read cycle would land before the low byte read
    assign blk = hi_rd[n];
    // A held capture lands in the cycle after the read
    assign cap_load[n] = (cap_evt[n] || hold_reg) && !blk;
    assign cap_val[n] = cap_evt[n] ? i_free_running_count : hold_val_reg;
    assign cap_set[P] = cap_evt[n];

    // Edge history and the capture held over a blocked cycle
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        prev_reg <= 1'b0;
        hold_reg <= 1'b0;
      end else begin
        prev_reg <= i_port_a[P];
        hold_reg <= blk && (cap_evt[n] || hold_reg);
      end
    end

    // The count is sampled at the edge it settled before; it moves after
    always_ff @(posedge i_mclk) begin
      if (cap_evt[n]) begin
        hold_val_reg <= i_free_running_count;
      end
    end

    property p_cap_take;
      (cap_evt[n] && !blk) |=> (val[n] == $past(i_free_running_count));
    endproperty
    a_cap_take: assert property (p_cap_take) else $error("capture missed count");

    property p_cap_block;
      blk |=> (val[n] == $past(val[n]));
    endproperty
    a_cap_block: assert property (p_cap_block) else $error("capture during block");

    property p_cap_held;
      (cap_evt[n] && blk) ##1 (!cap_evt[n] && !blk) |=>
        (val[n] == $past(i_free_running_count, 2));
    endproperty
    a_cap_held: assert property (p_cap_held) else $error("held capture lost");

    property p_cap_off;
      (edge_sel_reg[E+1:E] == 2'b00) |-> !cap_evt[n];
    endproperty
    a_cap_off: assert property (p_cap_off) else $error("disabled channel fired");
  end

  // ************************************************************
  // Output compare channels
  // ************************************************************
  for (genvar c = 0; c < tcc_pkg::NUM_COMPARE; c++) begin : g_cmp
    localparam int V = (c == 4) ? tcc_pkg::SHARED_INDEX : tcc_pkg::COMPARE_ONE_INDEX + c;
    localparam int F = 7 - c;
    logic inh_reg;
    logic pend_reg;
    logic en;
    // Matching only on a fresh count avoids repeats under prescale
    assign en = (c != 4) || !func_sel_reg;
    assign match[c] = en && !inh_reg && i_count_tick &&
                      (val[V] == i_free_running_count);
    assign force_go[c] = en && pend_reg && i_count_tick;
    assign cmp_evt[c] = match[c] || force_go[c];
    assign cmp_set[F] = match[c];

    // Force is held only until the next count transition
    always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
        inh_reg <= 1'b0;
        pend_reg <= 1'b0;
      end else begin
        inh_reg <= hi_wr[V];
        if (force_wr && i_wr_data[F]) begin
          pend_reg <= 1'b1;
        end else if (i_count_tick) begin
          pend_reg <= 1'b0;
        end
      end
    end

    property p_cmp_inhibit;
      inh_reg |-> !match[c];
    endproperty
    a_cmp_inhibit: assert property (p_cmp_inhibit) else $error("match while inhibited");

    property p_force_noflag;
      (force_go[c] && !match[c] && !flag_reg[F]) |=> !flag_reg[F];
    endproperty
    a_force_noflag: assert property (p_force_noflag) else $error("force set a flag");
  end

  // ************************************************************
  // Port A pin drivers
  // ************************************************************
  for (genvar q = tcc_pkg::PIN_LOW; q <= tcc_pkg::PIN_HIGH; q++) begin : g_pin
    logic [1:0] act;
    logic own_on;
    logic own_ev;
    logic master;
    if (q < tcc_pkg::PIN_HIGH) begin : g_own
      assign act = action_reg[2*q-5:2*q-6];
      assign own_ev = cmp_evt[7-q];
    end else begin : g_none
      assign act = tcc_pkg::ACT_OFF;
      assign own_ev = 1'b0;
    end
    // Fifth compare gives up its pin in capture mode
    assign own_on = (act != tcc_pkg::ACT_OFF) &&
                    ((q != tcc_pkg::PIN_LOW) || !func_sel_reg);
    assign master = cmp_evt[0] && mask_reg[q];
    // Master compare takes priority over the pin's own channel
    assign pin_next[q] = master ? data_reg[q] :
                         !(own_ev && own_on) ? o_port_a_out[q] :
                         (act == tcc_pkg::ACT_TOGGLE) ? !o_port_a_out[q] : act[0];
    assign oe_next[q] = mask_reg[q] || own_on;
  end

  // Pins and their enables come straight from flops
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_port_a_out <= 5'h00;
      o_port_a_oe <= 5'h00;
    end else begin
      o_port_a_out <= pin_next;
      o_port_a_oe <= oe_next;
    end
  end

  // ************************************************************
  // Read path and interrupt
  // ************************************************************
  // Unmapped addresses and force register read zero
  always_comb begin
    rd_mux = 8'h00;
    if (i_addr == tcc_pkg::ADDR_EDGE_SEL) begin
      rd_mux = edge_sel_reg;
    end else if (i_addr == tcc_pkg::ADDR_PIN_MASK) begin
      rd_mux = mask_reg;
    end else if (i_addr == tcc_pkg::ADDR_PIN_DATA) begin
      rd_mux = data_reg;
    end else if (i_addr == tcc_pkg::ADDR_ACTION) begin
      rd_mux = action_reg;
    end else if (i_addr == tcc_pkg::ADDR_FLAG) begin
      rd_mux = flag_reg;
    end else if (i_addr == tcc_pkg::ADDR_IRQ_MASK) begin
      rd_mux = irq_mask_reg;
    end else if (i_addr == tcc_pkg::ADDR_FUNC_SEL) begin
      rd_mux = {7'h00, func_sel_reg};
    end
    for (int k = 0; k < tcc_pkg::NUM_VALUES; k++) begin
      if (i_addr == tcc_pkg::ADDR_VALUE_BASE + 5'(2 * k)) begin
        rd_mux = val[k][15:8];
      end
      if (i_addr == tcc_pkg::ADDR_VALUE_BASE + 5'(2 * k + 1)) begin
        rd_mux = val[k][7:0];
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_rd_data <= 8'h00;
      o_irq <= 1'b0;
    end else begin
      o_rd_data <= i_rd ? rd_mux : 8'h00;
      o_irq <= |(flag_reg & irq_mask_reg);
    end
  end

  property p_flag_clear;
    (i_wr && (i_addr == tcc_pkg::ADDR_FLAG) && i_wr_data[6] && !flag_set[6])
      |=> !flag_reg[6];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  property p_master_pin;
    (cmp_evt[0] && mask_reg[7]) |=> (o_port_a_out[7] == $past(data_reg[7]));
  endproperty
  a_master_pin: assert property (p_master_pin) else $error("master data not driven");

  property p_toggle;
    (cmp_evt[1] && (action_reg[7:6] == 2'b01) && !mask_reg[6])
      |=> (o_port_a_out[6] != $past(o_port_a_out[6]));
  endproperty
  a_toggle: assert property (p_toggle) else $error("toggle missed");

  property p_low_bits;
    (i_rd && (i_addr == tcc_pkg::ADDR_PIN_MASK)) |=> (o_rd_data[2:0] == 3'h0);
  endproperty
  a_low_bits: assert property (p_low_bits) else $error("mask low bits nonzero");

endmodule

/* tb/port_a_source.sv */
// Purpose: far-side model of the external signals on the capture pins
// Assumes: pins change only just after a rising edge of i_mclk
// Notes: the pins are driven inputs with no pull, so they always hold a level
`timescale 1ns/1ps
module port_a_source (
  input wire logic i_mclk,
  output logic [3:0] o_pins
);
  // Pins start low so the first edges seen after reset are known
  initial begin
    o_pins = 4'h0;
  end

  // Change the levels at once, for callers already just past an edge
  task automatic drive_now(input logic [3:0] lvl);
    o_pins <= lvl;
  endtask

  // Wait for an edge first, so a change never lands on a sampling edge
  task automatic drive(input logic [3:0] lvl);
    @(posedge i_mclk);
    drive_now(lvl);
  endtask
endmodule

/* tb/timer_capture_compare_unit_tb.sv */
// Purpose: self-checking bench for the timer capture/compare unit
// Assumes: the bench drives count and tick itself, so every count is exact
// Notes: count is held still while capturing, so expectations are known
`timescale 1ns/1ps
module timer_capture_compare_unit_tb;
  localparam logic [4:0] CAP1 = tcc_pkg::ADDR_VALUE_BASE;
  localparam logic [4:0] SHARED = tcc_pkg::ADDR_VALUE_BASE + 5'h06;
  localparam logic [4:0] CMP1 = tcc_pkg::ADDR_VALUE_BASE + 5'h08;
  localparam logic [4:0] CMP2 = tcc_pkg::ADDR_VALUE_BASE + 5'h0a;
  localparam logic [4:0] CMP3 = tcc_pkg::ADDR_VALUE_BASE + 5'h0c;
  logic i_mclk = 1'b0;
  logic i_rst_n;
  logic [4:0] i_addr;
  logic [7:0] i_wr_data;
  logic i_wr;
  logic i_rd;
  logic [15:0] cnt;
  logic tick;
  logic [3:0] pins;
  logic [7:0] o_rd_data;
  logic [7:3] pa_out;
  logic [7:3] pa_oe;
  logic o_irq;
  logic [15:0] v;
  int fails = 0;
  int total_checks = 0;

  // ************************************************************
  // Clock, partner and design
  // ************************************************************
  always #12.5 i_mclk = ~i_mclk;

  port_a_source port_a_source_inst (.i_mclk(i_mclk), .o_pins(pins));

  timer_capture_compare_unit timer_capture_compare_unit_inst (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wr_data(i_wr_data),
    .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data), .i_free_running_count(cnt),
    .i_count_tick(tick), .i_port_a(pins), .o_port_a_out(pa_out),
    .o_port_a_oe(pa_oe), .o_irq(o_irq));

  // ************************************************************
  // Shared tasks
  // ************************************************************
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wr_data <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // High then low byte back to back, so the pair reads coherently
  task automatic rd16(input logic [4:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_mclk);
    i_addr <= a + 5'h01;
    #1 v[15:8] = o_rd_data;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 v[7:0] = o_rd_data;
  endtask

  // A new count always comes with its one-cycle tick
  task automatic step(input logic [15:0] c);
    @(posedge i_mclk);
    cnt <= c;
    tick <= 1'b1;
    @(posedge i_mclk);
    tick <= 1'b0;
    repeat (3) @(posedge i_mclk);
    #1;
  endtask

  task automatic caps(input logic [15:0] e1, input logic [15:0] e2, input logic [15:0] e3);
    rd16(CAP1);
    chk("capture one", e1, v);
    rd16(CAP1 + 5'h02);
    chk("capture two", e2, v);
    rd16(CAP1 + 5'h04);
    chk("capture three", e3, v);
  endtask

  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_reset();
    for (int k = 0; k < 5; k++) begin
      rd16(SHARED + 5'(2 * k));
      chk("compare reset", tcc_pkg::COMPARE_RESET, v);
    end
    rd16(tcc_pkg::ADDR_EDGE_SEL);
    chk("edge select reset", 16'(tcc_pkg::CONTROL_RESET), 16'(v[15:8]));
    wr(tcc_pkg::ADDR_PIN_MASK, 8'hff);
    wr(tcc_pkg::ADDR_PIN_DATA, 8'hff);
    rd16(tcc_pkg::ADDR_PIN_MASK);
    chk("mask and data", 16'hf8f8, v);
    wr(tcc_pkg::ADDR_PIN_MASK, 8'h00);
    rd16(5'h1f);
    chk("unmapped", 16'h0000, 16'(v[15:8]));
    $display("test reset done");
  endtask

  task automatic t_capture();
    step(16'h1234);
    wr(tcc_pkg::ADDR_EDGE_SEL, 8'h3f);
    port_a_source_inst.drive(4'h7);
    caps(16'h1234, 16'h1234, 16'h1234);
    rd16(tcc_pkg::ADDR_FLAG);
    chk("capture flags", 16'h0007, 16'(v[10:8]));
    step(16'h2222);
    wr(tcc_pkg::ADDR_EDGE_SEL, 8'h18);
    port_a_source_inst.drive(4'h0);
    caps(16'h1234, 16'h2222, 16'h1234);
    step(16'h3333);
    port_a_source_inst.drive(4'h7);
    caps(16'h3333, 16'h2222, 16'h1234);
    step(16'h4444);
    wr(tcc_pkg::ADDR_EDGE_SEL, 8'h40);
    port_a_source_inst.drive(4'hf);
    rd16(SHARED);
    chk("fourth off", 16'hffff, v);
    wr(tcc_pkg::ADDR_FUNC_SEL, 8'h01);
    port_a_source_inst.drive(4'h7);
    port_a_source_inst.drive(4'hf);
    rd16(SHARED);
    chk("fourth on", 16'h4444, v);
    $display("test capture done");
  endtask

  // Reset in mid-run; the capture pair must survive it
  task automatic t_keep();
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    repeat (2) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rd16(CAP1);
    chk("capture kept", 16'h3333, v);
    rd16(SHARED);
    chk("shared reset", 16'hffff, v);
    wr(tcc_pkg::ADDR_EDGE_SEL, 8'h30);
    step(16'h4455);
    // Edge lands in the high byte read cycle, so its transfer must wait
    fork
      rd16(CAP1);
      port_a_source_inst.drive(4'hb);
    join
    chk("coherent pair", 16'h3333, v);
    rd16(CAP1);
    chk("held capture", 16'h4455, v);
    $display("test keep done");
  endtask

  task automatic t_compare();
    wr(CMP2, 8'h01);
    wr(CMP2 + 5'h01, 8'h00);
    wr(tcc_pkg::ADDR_ACTION, 8'hc0);
    wr(tcc_pkg::ADDR_IRQ_MASK, 8'h40);
    step(16'h0100);
    chk("set pin", 16'h0003, {14'h0000, pa_oe[6], pa_out[6]});
    chk("irq", 16'h0001, 16'(o_irq));
    wr(tcc_pkg::ADDR_FLAG, 8'h00);
    rd16(tcc_pkg::ADDR_FLAG);
    chk("flag kept", 16'h0001, 16'(v[14]));
    wr(tcc_pkg::ADDR_ACTION, 8'h80);
    step(16'h0101);
    step(16'h0100);
    chk("clear pin", 16'h0000, 16'(pa_out[6]));
    wr(tcc_pkg::ADDR_ACTION, 8'h40);
    step(16'h0101);
    step(16'h0100);
    chk("toggle pin", 16'h0001, 16'(pa_out[6]));
    wr(tcc_pkg::ADDR_ACTION, 8'h00);
    wr(tcc_pkg::ADDR_FLAG, 8'h40);
    rd16(tcc_pkg::ADDR_FLAG);
    chk("flag cleared", 16'h0000, {15'h0000, v[14]});
    chk("pin released", 16'h0000, {15'h0000, pa_oe[6]});
    chk("irq low", 16'h0000, 16'(o_irq));
    $display("test compare done");
  endtask

  // Tick lands in the cycle right after the high byte write
  task automatic t_suppress();
    wr(CMP3 + 5'h01, 8'h00);
    wr(CMP3, 8'h02);
    cnt <= 16'h0200;
    tick <= 1'b1;
    @(posedge i_mclk);
    tick <= 1'b0;
    rd16(tcc_pkg::ADDR_FLAG);
    chk("suppressed", 16'h0000, 16'(v[13]));
    step(16'h0201);
    step(16'h0200);
    rd16(tcc_pkg::ADDR_FLAG);
    chk("later match", 16'h0001, 16'(v[13]));
    $display("test suppress done");
  endtask

  task automatic t_master();
    wr(tcc_pkg::ADDR_PIN_MASK, 8'h88);
    wr(tcc_pkg::ADDR_PIN_DATA, 8'h80);
    wr(CMP1, 8'h03);
    wr(CMP1 + 5'h01, 8'h00);
    step(16'h0300);
    chk("master pins", 16'h0238, 16'({pa_oe, pa_out}));
    // Shared pair is the fifth compare while function select is clear
    wr(SHARED, 8'h05);
    wr(SHARED + 5'h01, 8'h00);
    wr(tcc_pkg::ADDR_ACTION, 8'h03);
    step(16'h0500);
    chk("fifth compare pin", 16'h0003, {14'h0000, pa_oe[3], pa_out[3]});
    $display("test master done");
  endtask

  // Only a clearing channel is forced, never a toggling one
  task automatic t_force();
    wr(tcc_pkg::ADDR_ACTION, 8'h80);
    wr(tcc_pkg::ADDR_FLAG, 8'hff);
    wr(tcc_pkg::ADDR_FORCE, 8'h40);
    rd16(tcc_pkg::ADDR_FORCE);
    chk("force reads", 16'h0000, 16'(v[15:8]));
    chk("before tick", 16'h0001, 16'(pa_out[6]));
    step(16'h0400);
    chk("forced pin", 16'h0000, 16'(pa_out[6]));
    rd16(tcc_pkg::ADDR_FLAG);
    chk("no flag", 16'h0000, 16'(v[15:8]));
    $display("test force done");
  endtask

  // ************************************************************
  // Run control
  // ************************************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run is a few hundred cycles; this margin is generous
  initial begin
    #(25 * 30000);
    fails++;
    final_report();
  end

  initial begin
    i_rst_n = 1'b0;
    i_addr = 5'h00;
    i_wr_data = 8'h00;
    i_wr = 1'b0;
    i_rd = 1'b0;
    cnt = 16'h0000;
    tick = 1'b0;
    repeat (12) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_capture();
    t_keep();
    t_compare();
    t_suppress();
    t_master();
    t_force();
    final_report();
  end
endmodule
